// ---- design/store_conditional_unit.sv ----
/*
 conditional word store unit: decodes the conditional store, forms and
 checks its address, places the lanes, gates the store on the link flag,
 and returns the success word. apb registers hold endian controls, link status and fail count.
 assumes the pipeline gives one issue pulse with register values already
 read, translation returns the physical address the same cycle, and
 snoop/exception pulses come from core-clock logic.
*/
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - opcode 111000 with base, source/target and 16-bit offset fields
// - address is sign-extended offset plus base register
// - successful sequence writes low 32-bit word at aligned address
// - success writes 1 into the source/target register
// - failure leaves memory alone and writes 0
// - coherent store by another agent into monitored block fails it
// - any exception taken between linked load and store fails it
// - loads, stores, prefetches in between give either outcome
// - sequence outside one 2048-byte region gives either outcome
// - either low address bit set raises address error, no store
// - word store issued only while link flag is set
// - result written back is 63 zeros then the link flag, cleared by a snoop or exception in the same cycle
// - lane is address xor endian bit, data shifted by eight per lane
// - only tlb refill/invalid/modified and address error raised, never reserved
//////////////////////////////////////////////////////////////////////////////
module store_conditional_unit #(
    parameter int PA_W   = 36,
    parameter int BLK_W  = 4
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            issue_valid,
    input  wire logic [31:0]     instr_word,
    input  wire logic [63:0]     base_value,
    input  wire logic [63:0]     source_value,
    input  wire logic            xlate_refill,
    input  wire logic            xlate_invalid,
    input  wire logic            xlate_modified,
    input  wire logic [PA_W-1:0] xlate_paddr,
    input  wire logic [2:0]      xlate_attr,
    input  wire logic            ll_done,
    input  wire logic [PA_W-1:0] ll_paddr,
    input  wire logic            snoop_store,
    input  wire logic [PA_W-1:0] snoop_paddr,
    input  wire logic            core_exception,
    output logic [63:0]          vaddr,
    output logic                 mem_store,
    output logic [PA_W-1:0]      mem_paddr,
    output logic [63:0]          mem_data,
    output logic [7:0]           mem_byte_en,
    output logic [2:0]           cache_coherency_attr,
    output logic                 wb_valid,
    output logic [4:0]           wb_reg,
    output logic [63:0]          wb_value,
    output logic                 exc_valid,
    output logic [7:0]           exc_code,
    output logic                 link_flag,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic [31:0]          prdata,
    output logic                 pready,
    output logic                 pslverr
);
    //////////////////////////////////////////////////////////////////////////
    // decode and address
    wire logic is_sc = issue_valid &&
        instr_word[sc_pkg::OP_MSB:sc_pkg::OP_LSB] == sc_pkg::OP_STORE_COND;
    wire logic [4:0] rt_idx = instr_word[sc_pkg::RT_MSB:sc_pkg::RT_LSB];
    wire logic [63:0] ofs_ext =
        {{48{instr_word[sc_pkg::OFS_MSB]}}, instr_word[15:0]};
    wire logic [63:0] ea = base_value + ofs_ext;
    assign vaddr = ea;
    wire logic misalign = ea[1] | ea[0];
    wire logic tlb_fault = xlate_refill | xlate_invalid | xlate_modified;
    wire logic sc_exc = is_sc && (misalign || tlb_fault);
    wire logic sc_ok = is_sc && !sc_exc;

    //////////////////////////////////////////////////////////////////////////
    // apb registers
    logic [31:0] ctrl_q;
    logic [31:0] fail_cnt_q;
    logic [31:0] prdata_q;
    wire logic apb_wr = psel && penable && pwrite;
    wire logic apb_rd = psel && !penable && !pwrite;
    wire logic hit_ctrl = paddr == sc_pkg::ADDR_CTRL;
    wire logic hit_stat = paddr == sc_pkg::ADDR_STATUS;
    wire logic hit_cnt  = paddr == sc_pkg::ADDR_COUNT;
    wire logic hit_any  = hit_ctrl | hit_stat | hit_cnt;
    wire logic core_msb_first = ctrl_q[sc_pkg::CTRL_MSB_FIRST];
    wire logic swap_byte_order_user = ctrl_q[sc_pkg::CTRL_SWAP_USER];
    wire logic sw_clear = apb_wr && hit_ctrl && pwdata[sc_pkg::CTRL_CLEAR];
    wire logic [31:0] rd_mux =
        hit_ctrl ? ctrl_q :
        hit_stat ? {31'h0000_0000, link_flag} :
        hit_cnt  ? fail_cnt_q : 32'h0000_0000;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata  = prdata_q;

    //////////////////////////////////////////////////////////////////////////
    // lane placement
    wire logic [2:0] lane = ea[2:0] ^ {core_msb_first, 2'b00};
    wire logic [PA_W-1:0] pa_swz = {xlate_paddr[PA_W-1:3],
        xlate_paddr[2:0] ^ {swap_byte_order_user, 2'b00}};
    wire logic [5:0] shamt = {lane, 3'b000};
    wire logic [63:0] data_sh = source_value << shamt;
    wire logic [7:0] be_sh = 8'h0f << lane;

    //////////////////////////////////////////////////////////////////////////
    // link flag
    // block compare ignores the low BLK_W bits: word to a small block.
    function automatic logic same_block(input logic [PA_W-1:0] a,
                                        input logic [PA_W-1:0] b);
        same_block = (a >> BLK_W) == (b >> BLK_W);
    endfunction
    logic [PA_W-1:0] link_pa_q;
    logic            link_q;
    wire logic snoop_kill = snoop_store && same_block(snoop_paddr, link_pa_q);
    // a consumed store also ends the sequence; the set wins on collision
    // local loads and fetch distance are left out of kill on purpose:
    // either outcome is allowed there, and ignoring them is cheapest
    wire logic kill = snoop_kill || core_exception || sc_exc
        || is_sc;
    wire logic link_d = ll_done ? 1'b1 : (kill ? 1'b0 : link_q);
    assign link_flag = link_q;
    // snoop in the same cycle as the store also fails it, safest reading
    wire logic live_link = link_q && !snoop_kill && !core_exception;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_q    <= 1'b0;
            link_pa_q <= '0;
        end else begin
            link_q <= link_d;
            if (ll_done) begin
                link_pa_q <= ll_paddr;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs registered one cycle after issue
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_store            <= 1'b0;
            mem_paddr            <= '0;
            mem_data             <= 64'h0000_0000_0000_0000;
            mem_byte_en          <= 8'h00;
            cache_coherency_attr <= 3'h0;
            wb_valid             <= 1'b0;
            wb_reg               <= 5'h00;
            wb_value             <= 64'h0000_0000_0000_0000;
            exc_valid            <= 1'b0;
            exc_code             <= sc_pkg::EXC_NONE;
        end else begin
            mem_store <= sc_ok && live_link;
            if (sc_ok) begin
                mem_paddr            <= pa_swz;
                mem_data             <= data_sh;
                mem_byte_en          <= be_sh;
                cache_coherency_attr <= xlate_attr;
            end
            wb_valid <= sc_ok;
            if (sc_ok) begin
                wb_reg   <= rt_idx;
                wb_value <= {63'h0, live_link};
            end
            exc_valid <= sc_exc;
            exc_code  <= misalign ? sc_pkg::EXC_ADDR_ERROR :
                         tlb_fault ? sc_pkg::EXC_TLB_FAULT :
                         sc_pkg::EXC_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= sc_pkg::CTRL_RESET;
            fail_cnt_q <= 32'h0000_0000;
            prdata_q   <= 32'h0000_0000;
        end else begin
            if (apb_wr && hit_ctrl) begin
                ctrl_q <= pwdata & 32'h0000_0003;
            end
            if (sw_clear) begin
                fail_cnt_q <= 32'h0000_0000;
            end else if (sc_ok && !live_link) begin
                fail_cnt_q <= fail_cnt_q + 32'h0000_0001;
            end
            if (apb_rd) begin
                prdata_q <= rd_mux;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    store_gate_a: assert property (mem_store |-> $past(link_q))
        else $error("store issued without link flag");
    result_val_a: assert property (wb_valid |-> wb_value[63:1] == 63'h0
        && wb_value[0] == mem_store)
        else $error("writeback not flag word");
    misalign_a: assert property (is_sc && misalign |=> exc_valid
        && !mem_store && exc_code == sc_pkg::EXC_ADDR_ERROR)
        else $error("misaligned store not trapped");
    success_a: assert property (sc_ok && live_link |=> mem_store
        && wb_value == 64'h0000_0000_0000_0001)
        else $error("success not reported");
    fail_a: assert property (sc_ok && !live_link |=> !mem_store
        && wb_value == 64'h0000_0000_0000_0000)
        else $error("failure not reported");
    snoop_kill_a: assert property (snoop_kill && !ll_done |=> !link_q)
        else $error("snoop did not clear link");
    exc_kill_a: assert property (core_exception && !ll_done |=> !link_q)
        else $error("exception did not clear link");
    ll_set_a: assert property (ll_done |=> link_q)
        else $error("linked load did not set flag");
    lane_a: assert property (sc_ok |=> mem_byte_en ==
        (8'h0f << $past(lane)))
        else $error("byte enable lane wrong");
    decode_a: assert property (issue_valid && instr_word[31:26] != 6'h38
        |=> !wb_valid && !exc_valid)
        else $error("non-matching opcode acted on");


    //////////////////////////////////////////////////////////////////////////
    // trap path, link upkeep, placement and register side
    // a trap must never leave a store or a writeback behind it
    tlb_trap_a: assert property (is_sc && !misalign && tlb_fault |=> exc_valid
        && !mem_store && !wb_valid
        && exc_code == sc_pkg::EXC_TLB_FAULT)
        else $error("translation fault not trapped");
    exc_no_wb_a: assert property (exc_valid |-> !wb_valid && !mem_store)
        else $error("trap came with a writeback");
    no_exc_idle_a: assert property (!is_sc |=> !exc_valid)
        else $error("trap without a store issue");
    no_store_idle_a: assert property (!is_sc |=> !mem_store && !wb_valid)
        else $error("store without an issue");
    consume_a: assert property (is_sc && !ll_done |=> !link_q)
        else $error("store did not consume link");
    link_hold_a: assert property (!ll_done && !kill |=>
        link_q == $past(link_q))
        else $error("link flag changed on its own");
    wb_reg_a: assert property (sc_ok |=> wb_reg == $past(rt_idx))
        else $error("writeback register wrong");
    data_lane_a: assert property (sc_ok |=> mem_data ==
        ($past(source_value) << {$past(lane), 3'b000}))
        else $error("store data lane wrong");
    paddr_low_a: assert property (sc_ok |=> mem_paddr[2:0] ==
        ($past(xlate_paddr[2:0]) ^ {$past(swap_byte_order_user), 2'b00}))
        else $error("physical lane swizzle wrong");
    paddr_high_a: assert property (sc_ok |=> mem_paddr[PA_W-1:3] ==
        $past(xlate_paddr[PA_W-1:3]))
        else $error("physical address upper bits wrong");
    attr_pass_a: assert property (sc_ok |=>
        cache_coherency_attr == $past(xlate_attr))
        else $error("access type not passed on");
    stat_read_a: assert property (apb_rd && hit_stat |=>
        prdata == {31'h0, $past(link_q)})
        else $error("status read wrong");
    // the count only tells software how often it retried; it may wrap
    fail_cnt_a: assert property (sc_ok && !live_link && !sw_clear |=>
        fail_cnt_q == $past(fail_cnt_q) + 32'h0000_0001)
        else $error("failed store not counted");
    cnt_clear_a: assert property (sw_clear |=>
        fail_cnt_q == 32'h0000_0000)
        else $error("fail count not cleared");

    cov_success_c: cover property (ll_done ##[1:8] (sc_ok && live_link));
    cov_exc_c: cover property (ll_done ##1 core_exception ##[1:8] sc_ok);
    cov_tlb_c: cover property (is_sc && tlb_fault && !misalign);
    cov_snoop_c: cover property (ll_done ##1 snoop_kill ##[1:8] sc_ok);
    cov_misalign_c: cover property (is_sc && misalign);
endmodule

// ---- design/sc_pkg.sv ----
/*
 package for the conditional word store unit: opcode, field positions,
 lane and cache attribute codes, apb map.
 assumes nothing beyond a systemverilog compiler.
*/
package sc_pkg;
    localparam logic [5:0]  OP_STORE_COND   = 6'h38;
    localparam logic [5:0]  OP_LOAD_LINKED  = 6'h30;
    localparam int          OP_MSB          = 31;
    localparam int          OP_LSB          = 26;
    localparam int          BASE_MSB        = 25;
    localparam int          BASE_LSB        = 21;
    localparam int          RT_MSB          = 20;
    localparam int          RT_LSB          = 16;
    localparam int          OFS_MSB         = 15;
    localparam int          LANE_SHIFT      = 3;
    localparam logic [2:0]  CCA_NONCOHERENT = 3'h3;
    localparam logic [2:0]  CCA_COHERENT    = 3'h5;
    localparam logic [7:0]  EXC_NONE        = 8'h00;
    localparam logic [7:0]  EXC_ADDR_ERROR  = 8'h05;
    localparam logic [7:0]  EXC_TLB_FAULT   = 8'h02;
    localparam logic [7:0]  EXC_RESERVED    = 8'h0a;
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_STATUS     = 12'h004;
    localparam logic [11:0] ADDR_COUNT      = 12'h008;
    localparam int          CTRL_MSB_FIRST  = 0;
    localparam int          CTRL_SWAP_USER  = 1;
    localparam int          CTRL_CLEAR      = 2;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
endpackage

// ---- verif/coherent_mem_model.sv ----
/*
 far-side model: coherent memory system plus a foreign agent that can
 store into a watched block. assumes one-cycle store pulses, core clock.
*/
`timescale 1ns/1ns
module coherent_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_store,
    input  wire logic [63:0] mem_data,
    input  wire logic        foreign_req,
    input  wire logic [35:0] foreign_addr,
    output logic             snoop_store,
    output logic [35:0]      snoop_paddr,
    output logic [7:0]       store_count,
    output logic [63:0]      last_data
);
//////////////////////////////////////////////////////////////////////////////
// idle address toggles so a stale match cannot pass by luck
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        snoop_store <= 1'b0;
        snoop_paddr <= 36'h0_0000_0000;
    end else begin
        snoop_store <= foreign_req;
        snoop_paddr <= foreign_req ? foreign_addr : ~snoop_paddr;
    end
end
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        store_count <= 8'h00;
        last_data   <= 64'h0000_0000_0000_0000;
    end else if (mem_store) begin
        store_count <= store_count + 8'h01;
        last_data   <= mem_data;
    end
end
endmodule

// ---- verif/store_conditional_unit_test.sv ----
/*
 bench for the conditional word store unit: link, snoop, exception,
 fault, lane and apb scenarios. assumes the far-side model beside it.
*/
`timescale 1ns/1ns
module store_conditional_unit_test;
logic        pclk, presetn, issue_valid, ll_done, core_exception, foreign_req;
logic        xlate_refill, xlate_invalid, xlate_modified, psel, penable;
logic        pwrite, mem_store, wb_valid, exc_valid, link_flag, pready;
logic        pslverr, snoop_store, err;
logic [31:0] instr_word, pwdata, prdata, rd;
logic [63:0] base_value, source_value, vaddr, mem_data, wb_value, last_data;
logic [35:0] xlate_paddr, ll_paddr, snoop_paddr, mem_paddr, foreign_addr;
logic [11:0] paddr;
logic [7:0]  mem_byte_en, exc_code, store_count;
logic [4:0]  wb_reg;
logic [2:0]  xlate_attr, cache_coherency_attr;
int          n_fail, check_count;
localparam logic [63:0] BASE = 64'h0000_0000_0000_1000;
localparam logic [35:0] BLK  = 36'h0_0010_1000;
store_conditional_unit dut_u (.pclk, .presetn, .issue_valid, .instr_word,
    .base_value, .source_value, .xlate_refill, .xlate_invalid,
    .xlate_modified, .xlate_paddr, .xlate_attr, .ll_done, .ll_paddr,
    .snoop_store, .snoop_paddr, .core_exception, .vaddr, .mem_store,
    .mem_paddr, .mem_data, .mem_byte_en, .cache_coherency_attr, .wb_valid,
    .wb_reg, .wb_value, .exc_valid, .exc_code, .link_flag, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
coherent_mem_model mem_u (.pclk, .presetn, .mem_store, .mem_data,
    .foreign_req, .foreign_addr, .snoop_store, .snoop_paddr, .store_count,
    .last_data);
always #5 pclk = ~pclk;
//////////////////////////////////////////////////////////////////////////////
task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task automatic apb(input logic wr, input logic [11:0] a,
                   input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
        @(posedge pclk);
        n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
        n_fail++;
        test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
endtask
// k: bit0 linked load, bit1 foreign store, bit2 local exception
task automatic ev(input logic [2:0] k, input logic [35:0] a);
    @(posedge pclk);
    ll_done        <= k[0];
    foreign_req    <= k[1];
    core_exception <= k[2];
    ll_paddr       <= a;
    foreign_addr   <= a;
    @(posedge pclk);
    ll_done        <= 1'b0;
    foreign_req    <= 1'b0;
    core_exception <= 1'b0;
    @(posedge pclk);
endtask
task automatic sc(input logic [15:0] ofs, input logic [2:0] flt,
                  input logic ok, input logic [7:0] ec,
                  input logic [1:0] ctl);
    logic [63:0] ea;
    logic [2:0]  ln;
    ea = BASE + {{48{ofs[15]}}, ofs};
    ln = ea[2:0] ^ {ctl[0], 2'b00};
    @(posedge pclk);
    issue_valid <= 1'b1;
    instr_word  <= {sc_pkg::OP_STORE_COND, 5'h03, 5'h09, ofs};
    {xlate_modified, xlate_invalid, xlate_refill} <= flt;
    xlate_paddr <= {20'h0_0010, ea[15:0]};
    @(posedge pclk);
    issue_valid <= 1'b0;
    #1;
    chk(vaddr, ea);
    chk(exc_valid, ec != 8'h00);
    if (ec != 8'h00) chk(exc_code, ec);
    chk(wb_valid, ec == 8'h00);
    chk(wb_reg, 5'h09);
    chk(wb_value, {63'h0, ok && ec == 8'h00});
    chk(mem_store, ok && ec == 8'h00);
    if (ok && ec == 8'h00) begin
        chk(mem_data, source_value << (8 * ln));
        chk(mem_byte_en, 8'h0f << ln);
        chk(mem_paddr, xlate_paddr ^ {33'h0, ctl[1], 2'b00});
        chk(cache_coherency_attr, sc_pkg::CCA_COHERENT);
    end
endtask
//////////////////////////////////////////////////////////////////////////////
task automatic t_link();
    ev(3'b001, BLK);
    chk(link_flag, 1'b1);
    sc(16'h0004, 3'b000, 1'b1, 8'h00, 2'b00);
    chk(link_flag, 1'b0);
    sc(16'h0000, 3'b000, 1'b0, 8'h00, 2'b00);
    chk(store_count, 8'h01);
    chk(last_data, source_value << 32);
    $display("test link done");
endtask
task automatic t_break();
    ev(3'b001, BLK);
    ev(3'b010, BLK + 36'h4);
    sc(16'h0000, 3'b000, 1'b0, 8'h00, 2'b00);
    ev(3'b001, BLK);
    ev(3'b010, BLK + 36'h40);
    sc(16'h0000, 3'b000, 1'b1, 8'h00, 2'b00);
    ev(3'b001, BLK);
    ev(3'b100, BLK);
    sc(16'h0000, 3'b000, 1'b0, 8'h00, 2'b00);
    $display("test break done");
endtask
task automatic t_fault();
    ev(3'b001, BLK);
    sc(16'h0002, 3'b001, 1'b0, 8'h05, 2'b00);
    chk(link_flag, 1'b0);
    for (int i = 0; i < 3; i++) begin
        ev(3'b001, BLK);
        sc(16'h0000, 3'b001 << i, 1'b0, 8'h02, 2'b00);
    end
    $display("test fault done");
endtask
task automatic t_regs();
    apb(1'b1, sc_pkg::ADDR_CTRL, 32'h0000_0003);
    ev(3'b001, BLK);
    apb(1'b0, sc_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    sc(16'hfffc, 3'b000, 1'b1, 8'h00, 2'b11);
    apb(1'b0, sc_pkg::ADDR_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, sc_pkg::ADDR_CTRL, 32'h0000_0004);
    apb(1'b0, sc_pkg::ADDR_COUNT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b0);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk(err, 1'b1);
    $display("test regs done");
endtask
initial begin
    {pclk, presetn, issue_valid, ll_done, core_exception, foreign_req} = '0;
    {xlate_refill, xlate_invalid, xlate_modified, psel, penable} = '0;
    {pwrite, paddr, pwdata, instr_word, ll_paddr, foreign_addr} = '0;
    base_value   = BASE;
    source_value = 64'h1122_3344_5566_7788;
    xlate_paddr  = BLK;
    xlate_attr   = sc_pkg::CCA_COHERENT;
    n_fail = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_link();
    t_break();
    t_fault();
    t_regs();
    test_done();
end
initial begin
    #200000;
    n_fail++;
    test_done();
end
endmodule
